// file: rtl/fslet_pkg.sv
// constants and carrier types for the firmware store loader and error trap
package fslet_pkg;
    // control store geometry
    localparam int CSA_W = 14;
    localparam int WORD_W = 96;
    localparam int DEPTH = 16384;
    localparam int SLICE_W = 16;
    localparam int PAR_GRP_W = 32;
    localparam int N_PAR_GRP = 3;
    localparam int BYTES = 4;
    localparam int BYTE_W = 8;
    localparam int CYC_W = 4;
    localparam int DEC_W = 3;
    // cycle(4,2,1) decodes of the ram store write op
    localparam logic [2:0] DEC_WRITE = 3'h0;
    localparam logic [2:0] DEC_ADDR = 3'h1;
    localparam logic [2:0] DEC_SLICE0 = 3'h2;
    // parity sense used in normal operation (odd)
    localparam logic PAR_ODD = 1'h1;
    // syndrome reason bits
    localparam int SYND_W = 8;
    localparam int SYN_DPAR = 0;
    localparam int SYN_PPAR = 1;
    localparam int SYN_DEDAC = 2;
    localparam int SYN_PEDAC = 3;
    localparam int SYN_NORESP = 4;
    localparam int SYN_CS0 = 5;
    localparam logic [SYND_W-1:0] SYND_RST = 8'h00;
    // step clock and no-response timeout
    localparam int CLK_NS = 10;
    localparam int NORESP_NS = 2000;
    localparam int NORESP_CYC = (NORESP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = $clog2(NORESP_CYC + 1);

    // microoperations issued in the current step
    typedef struct packed {
        logic ram_store_write_op;
        logic select_ram_array_op;
        logic select_rom_array_op;
        logic zbus_from_input_reg_a;
        logic zbus_from_input_reg_b;
        logic procedure_byte_take;
        logic dbus_from_procedure_buffer;
    } fslet_ops_t;

    // input data register contents as seen by the checker
    typedef struct packed {
        logic [BYTES*BYTE_W-1:0] data;
        logic [BYTES-1:0] par;
        logic [BYTES-1:0] byte_en;
        logic uncorr;
    } fslet_indata_t;

    // procedure buffer byte as seen by the checker
    typedef struct packed {
        logic [BYTE_W-1:0] data;
        logic par;
        logic uncorr;
    } fslet_proc_t;
endpackage

// file: rtl/fslet_cs_ram.sv
// loadable 16k x 96 control store array with registered read
`timescale 1ns/1ps
`default_nettype none
module fslet_cs_ram (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // write port
    input wire logic we_i,
    input wire logic [fslet_pkg::CSA_W-1:0] waddr_i,
    input wire logic [fslet_pkg::WORD_W-1:0] wdata_i,
    // read port
    input wire logic [fslet_pkg::CSA_W-1:0] raddr_i,
    output logic [fslet_pkg::WORD_W-1:0] rdata_o
);
    typedef struct packed {
        logic [fslet_pkg::WORD_W-1:0] rdata;
    } fslet_ram_st_t;

    logic [fslet_pkg::WORD_W-1:0] mem [fslet_pkg::DEPTH];
    fslet_ram_st_t s;
    fslet_ram_st_t next_s;

    always_comb begin
        next_s = s;
        next_s.rdata = mem[raddr_i];
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    // all 96 bits land in one word
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = s.rdata;

    property p_write_lands;
        @(posedge clk_i) disable iff (srst_i)
        we_i ##1 (raddr_i == $past(waddr_i) && !we_i) |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("ram word not written");
endmodule
`default_nettype wire

// file: rtl/fslet_top.sv
// control store array select, ram loader, parity checks and error trap
// Notes on behaviour
// - check parity on input register, procedure bytes
// - flag uncorrectable memory error on those sources
// - no response to transaction raises error
// - one parity bit per 32, three checks
// - error reloads syndrome, traps unless inhibited
// - syndrome holds reason code of error
// - generate parity for output data register
// - test mode forces even or odd parity
// - separate loadable 16k x 96 ram array
// - ram fetch as fast as rom fetch
// - initialization selects the rom array
// - ram writable only while running from rom
// - write op decodes cycle bits 4,2,1 only
// - decodes 2..7 load staging slices from z_bus
// - decode 1 loads pointer from d_bus 18-31
// - decode 0 writes staging word into ram
// - two ops switch between rom and ram
// - switch to active array does nothing
// - switch acts after following step completes
// - control store addresses are 14 bits
`timescale 1ns/1ps
`default_nettype none
module fslet_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // initialization: power-on, master clear or function 01
    input wire logic init_i,
    // step completion and microoperations of that step
    input wire logic step_i,
    input wire fslet_pkg::fslet_ops_t ops_i,
    input wire logic [fslet_pkg::CYC_W-1:0] cycle_i,
    input wire logic error_trap_inhibit_flag_i,
    // datapath buses
    input wire logic [31:0] z_bus_i,
    input wire logic [31:0] d_bus_i,
    // checked sources
    input wire fslet_pkg::fslet_indata_t indata_i,
    input wire fslet_pkg::fslet_proc_t proc_i,
    // system bus transactions
    input wire logic xact_start_i,
    input wire logic xact_resp_i,
    // control store fetch
    input wire logic fetch_i,
    input wire logic [fslet_pkg::CSA_W-1:0] control_store_address_i,
    input wire logic [fslet_pkg::WORD_W-1:0] rom_word_i,
    output logic [fslet_pkg::WORD_W-1:0] cs_word_o,
    output logic cs_valid_o,
    output logic ram_select_o,
    // error trap
    output logic [fslet_pkg::SYND_W-1:0] syndrome_o,
    output logic error_o,
    output logic trap_o,
    // output data register parity
    input wire logic [31:0] outr_i,
    input wire logic test_mode_i,
    input wire logic test_par_odd_i,
    output logic [fslet_pkg::BYTES-1:0] out_par_o
);
    typedef struct packed {
        logic sel_ram;
        logic pend;
        logic pend_ram;
        logic [fslet_pkg::WORD_W-1:0] fws;
        logic [fslet_pkg::CSA_W-1:0] fwp;
        logic fetch_q;
        logic fetch_ram;
        logic [fslet_pkg::WORD_W-1:0] rom_q;
        logic [fslet_pkg::WORD_W-1:0] cs_word;
        logic cs_valid;
        logic [fslet_pkg::SYND_W-1:0] synd;
        logic err;
        logic trap;
        logic [fslet_pkg::BYTES-1:0] out_par;
        logic nr_busy;
        logic [fslet_pkg::CNT_W-1:0] nr_cnt;
    } fslet_st_t;

    fslet_st_t s;
    fslet_st_t next_s;
    logic [fslet_pkg::WORD_W-1:0] ram_rdata;
    logic ram_we;
    logic [fslet_pkg::BYTES-1:0] dbyte_bad;
    logic [fslet_pkg::BYTES-1:0] gen_par;
    logic [fslet_pkg::N_PAR_GRP-1:0] cs_bad;
    logic [fslet_pkg::SYND_W-1:0] reasons;
    logic par_sense;
    logic use_in;
    logic use_proc;
    logic [fslet_pkg::DEC_W-1:0] dec;
    logic wr_ok;
    logic nr_timeout;

    // parity sense, test mode may force either
    assign par_sense = test_mode_i ? test_par_odd_i : fslet_pkg::PAR_ODD;

    // per byte data parity check and output parity generation
    for (genvar b = 0; b < fslet_pkg::BYTES; b++) begin : g_byte
        assign dbyte_bad[b] = indata_i.byte_en[b]
            && ((^indata_i.data[b*fslet_pkg::BYTE_W +: fslet_pkg::BYTE_W])
                ^ indata_i.par[b]) != fslet_pkg::PAR_ODD;
        assign gen_par[b] = (^outr_i[b*fslet_pkg::BYTE_W +: fslet_pkg::BYTE_W])
            ^ par_sense;
    end

    // three parity groups of the fetched word, each carries its own bit
    for (genvar g = 0; g < fslet_pkg::N_PAR_GRP; g++) begin : g_csgrp
        assign cs_bad[g] = s.cs_valid
            && (^s.cs_word[g*fslet_pkg::PAR_GRP_W +: fslet_pkg::PAR_GRP_W])
               != fslet_pkg::PAR_ODD;
    end

    assign use_in = step_i && (ops_i.zbus_from_input_reg_a || ops_i.zbus_from_input_reg_b);
    assign use_proc = step_i && (ops_i.procedure_byte_take
        || ops_i.dbus_from_procedure_buffer);
    assign nr_timeout = s.nr_busy && !xact_resp_i && !xact_start_i
        && s.nr_cnt == fslet_pkg::CNT_W'(fslet_pkg::NORESP_CYC - 1);

    // reason code sampled into the syndrome register
    always_comb begin
        reasons = '0;
        reasons[fslet_pkg::SYN_DPAR] = use_in && (|dbyte_bad);
        reasons[fslet_pkg::SYN_PPAR] = use_proc
            && ((^proc_i.data) ^ proc_i.par) != fslet_pkg::PAR_ODD;
        reasons[fslet_pkg::SYN_DEDAC] = use_in && indata_i.uncorr;
        reasons[fslet_pkg::SYN_PEDAC] = use_proc && proc_i.uncorr;
        reasons[fslet_pkg::SYN_NORESP] = nr_timeout;
        reasons[fslet_pkg::SYN_CS0 +: fslet_pkg::N_PAR_GRP] = cs_bad;
    end

    // only bits 4,2,1 of the cycle counter take part
    assign dec = cycle_i[fslet_pkg::DEC_W-1:0];
    assign wr_ok = step_i && ops_i.ram_store_write_op && !s.sel_ram;
    assign ram_we = wr_ok && dec == fslet_pkg::DEC_WRITE;

    always_comb begin
        int slice;
        slice = 0;
        next_s = s;
        next_s.err = 1'b0;
        next_s.trap = 1'b0;
        next_s.cs_valid = 1'b0;

        // staging word and pointer loads
        if (wr_ok) begin
            if (dec == fslet_pkg::DEC_ADDR) begin
                next_s.fwp = d_bus_i[fslet_pkg::CSA_W-1:0];
            end else if (dec >= fslet_pkg::DEC_SLICE0) begin
                slice = int'(dec - fslet_pkg::DEC_SLICE0);
                next_s.fws[fslet_pkg::WORD_W-1-slice*fslet_pkg::SLICE_W -: fslet_pkg::SLICE_W] =
                    z_bus_i[fslet_pkg::SLICE_W-1:0];
            end
        end

        // array switch takes effect when the following step completes
        if (step_i) begin
            if (s.pend) begin
                next_s.sel_ram = s.pend_ram;
                next_s.pend = 1'b0;
            end else if (ops_i.select_rom_array_op && s.sel_ram) begin
                next_s.pend = 1'b1;
                next_s.pend_ram = 1'b0;
            end else if (ops_i.select_ram_array_op && !ops_i.select_rom_array_op
                         && !s.sel_ram) begin
                next_s.pend = 1'b1;
                next_s.pend_ram = 1'b1;
            end
        end
        if (init_i) begin
            next_s.sel_ram = 1'b0;
            next_s.pend = 1'b0;
        end

        // two stage fetch, same latency for both arrays
        next_s.fetch_q = fetch_i;
        next_s.fetch_ram = s.sel_ram;
        if (fetch_i) begin
            next_s.rom_q = rom_word_i;
        end
        if (s.fetch_q) begin
            next_s.cs_word = s.fetch_ram ? ram_rdata : s.rom_q;
            next_s.cs_valid = 1'b1;
        end

        // no response watchdog
        if (xact_start_i) begin
            next_s.nr_busy = 1'b1;
            next_s.nr_cnt = '0;
        end else if (s.nr_busy && (xact_resp_i || nr_timeout)) begin
            next_s.nr_busy = 1'b0;
        end else if (s.nr_busy) begin
            next_s.nr_cnt = s.nr_cnt + fslet_pkg::CNT_W'(1);
        end

        // error capture and trap to location zero
        if (|reasons) begin
            next_s.synd = reasons;
            next_s.err = 1'b1;
            next_s.trap = !error_trap_inhibit_flag_i;
        end

        next_s.out_par = gen_par;

        if (srst_i) begin
            next_s = '0;
            next_s.synd = fslet_pkg::SYND_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    // separate loadable array
    fslet_cs_ram u_ram (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .we_i(ram_we),
        .waddr_i(s.fwp),
        .wdata_i(s.fws),
        .raddr_i(control_store_address_i),
        .rdata_o(ram_rdata)
    );

    assign cs_word_o = s.cs_word;
    assign cs_valid_o = s.cs_valid;
    assign ram_select_o = s.sel_ram;
    assign syndrome_o = s.synd;
    assign error_o = s.err;
    assign trap_o = s.trap;
    assign out_par_o = s.out_par;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_switch_req;
        step_i && !s.pend && !init_i
            && ((ops_i.select_ram_array_op && !ops_i.select_rom_array_op && !s.sel_ram)
                || (ops_i.select_rom_array_op && s.sel_ram));
    endsequence

    sequence s_next_step;
        step_i && !init_i;
    endsequence

    property p_init_rom;
        init_i |=> !ram_select_o;
    endproperty
    a_init_rom: assert property (p_init_rom) else $error("init left ram selected");

    property p_switch_late;
        s_switch_req |=> $stable(ram_select_o) && s.pend;
    endproperty
    a_switch_late: assert property (p_switch_late) else $error("switch acted too early");

    property p_switch_lands;
        s.pend ##0 s_next_step |=> ram_select_o == $past(s.pend_ram) && !s.pend;
    endproperty
    a_switch_lands: assert property (p_switch_lands) else $error("switch did not land");

    property p_switch_noop;
        step_i && !s.pend && !init_i && ops_i.select_ram_array_op
            && !ops_i.select_rom_array_op && ram_select_o |=> !s.pend && ram_select_o;
    endproperty
    a_switch_noop: assert property (p_switch_noop) else $error("switch to active array acted");

    property p_ram_locked;
        step_i && ops_i.ram_store_write_op && ram_select_o |-> !ram_we
            ##1 ($stable(s.fws) && $stable(s.fwp));
    endproperty
    a_ram_locked: assert property (p_ram_locked) else $error("ram written from ram");

    property p_slice0;
        wr_ok && cycle_i[fslet_pkg::DEC_W-1:0] == fslet_pkg::DEC_SLICE0
            |=> s.fws[fslet_pkg::WORD_W-1 -: fslet_pkg::SLICE_W]
                == $past(z_bus_i[fslet_pkg::SLICE_W-1:0]);
    endproperty
    a_slice0: assert property (p_slice0) else $error("first slice not loaded");

    property p_pointer;
        wr_ok && cycle_i[fslet_pkg::DEC_W-1:0] == fslet_pkg::DEC_ADDR
            |=> s.fwp == $past(d_bus_i[fslet_pkg::CSA_W-1:0]);
    endproperty
    a_pointer: assert property (p_pointer) else $error("pointer not loaded");

    property p_trap;
        (|reasons) |=> error_o && syndrome_o == $past(reasons)
            && trap_o == !$past(error_trap_inhibit_flag_i) ##1 !trap_o || $past(|reasons);
    endproperty
    a_trap: assert property (p_trap) else $error("error not trapped");

    property p_cs_check;
        cs_valid_o && (^cs_word_o[fslet_pkg::PAR_GRP_W-1:0]) != fslet_pkg::PAR_ODD
            |=> syndrome_o[fslet_pkg::SYN_CS0] && error_o;
    endproperty
    a_cs_check: assert property (p_cs_check) else $error("bad store parity missed");

    property p_noresp;
        xact_start_i ##1 (!xact_resp_i && !xact_start_i)[*8] |-> !error_o || $past(|reasons);
    endproperty
    a_noresp: assert property (p_noresp) else $error("no response flagged early");

    property p_outpar;
        1'b1 |=> ((^$past(outr_i[fslet_pkg::BYTE_W-1:0])) ^ out_par_o[0])
            == $past(par_sense);
    endproperty
    a_outpar: assert property (p_outpar) else $error("output parity wrong");

    property p_outpar_hi;
        1'b1 |=> ((^$past(outr_i[fslet_pkg::BYTES*fslet_pkg::BYTE_W-1 -: fslet_pkg::BYTE_W]))
            ^ out_par_o[fslet_pkg::BYTES-1]) == $past(par_sense);
    endproperty
    a_outpar_hi: assert property (p_outpar_hi) else $error("top byte parity wrong");

    property p_init_pend;
        init_i |=> !s.pend;
    endproperty
    a_init_pend: assert property (p_init_pend) else $error("init left a switch pending");

    property p_fetch_lat;
        fetch_i |-> ##2 cs_valid_o && cs_word_o == ($past(ram_select_o, 2)
            ? $past(ram_rdata) : $past(rom_word_i, 2));
    endproperty
    a_fetch_lat: assert property (p_fetch_lat) else $error("fetch word late or wrong");

    property p_slice_last;
        wr_ok && (&cycle_i[fslet_pkg::DEC_W-1:0])
            |=> s.fws[fslet_pkg::SLICE_W-1:0] == $past(z_bus_i[fslet_pkg::SLICE_W-1:0]);
    endproperty
    a_slice_last: assert property (p_slice_last) else $error("last slice not loaded");

    property p_cs_groups;
        cs_valid_o && !((^cs_word_o[fslet_pkg::PAR_GRP_W-1:0])
            && (^cs_word_o[fslet_pkg::PAR_GRP_W +: fslet_pkg::PAR_GRP_W])
            && (^cs_word_o[2*fslet_pkg::PAR_GRP_W +: fslet_pkg::PAR_GRP_W]))
            |=> error_o && (|syndrome_o[fslet_pkg::SYN_CS0 +: fslet_pkg::N_PAR_GRP]);
    endproperty
    a_cs_groups: assert property (p_cs_groups) else $error("store group parity missed");

    property p_syndrome_hold;
        !(|reasons) |=> $stable(syndrome_o);
    endproperty
    a_syndrome_hold: assert property (p_syndrome_hold) else $error("syndrome lost");
endmodule
`default_nettype wire

// file: tb/fslet_far_model.sv
// far-side model: rom array contents and system bus responder
`timescale 1ns/1ps
`default_nettype none
module fslet_far_model (
    // clock
    input wire logic clk_i,
    // rom array lookup
    input wire logic [13:0] addr_i,
    input wire logic bad_par_i,
    output logic [95:0] rom_word_o,
    // system bus responder, delay 0 never answers
    input wire logic xact_start_i,
    input wire logic [7:0] resp_dly_i,
    output logic xact_resp_o
);
    logic [7:0] cnt = 8'h00;
    logic [31:0] grp;
    assign grp = {~^addr_i, 17'h00000, addr_i};
    assign rom_word_o = {grp, grp, grp ^ {bad_par_i, 31'h0}};
    always @(posedge clk_i) begin
        if (xact_start_i) begin
            cnt <= resp_dly_i;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
        xact_resp_o <= (cnt == 8'h01) && !xact_start_i;
    end
endmodule
`default_nettype wire

// file: tb/fslet_top_tb_top.sv
// self-checking bench for the firmware store loader and error trap
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module fslet_top_tb_top;
    typedef struct packed {logic tm; logic odd; logic [31:0] outr; logic [3:0] par;} fslet_row_t;
    localparam logic [13:0] A = 14'h1234;
    localparam logic [95:0] LW = {3{32'h0007_1100}};
    localparam fslet_pkg::fslet_ops_t OP_WR = 7'h40;
    localparam fslet_pkg::fslet_ops_t OP_RAM = 7'h20;
    localparam fslet_pkg::fslet_ops_t OP_ROM = 7'h10;
    localparam fslet_pkg::fslet_ops_t OP_INA = 7'h08;
    localparam fslet_pkg::fslet_ops_t OP_INB = 7'h04;
    localparam fslet_pkg::fslet_ops_t OP_PT = 7'h02;
    localparam fslet_pkg::fslet_ops_t OP_DP = 7'h01;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic init_i = 1'b0;
    logic step_i = 1'b0;
    logic fetch_i = 1'b0;
    logic xact_start_i = 1'b0;
    logic inh = 1'b0;
    logic test_mode_i = 1'b0;
    logic test_par_odd_i = 1'b0;
    logic bad_par = 1'b0;
    fslet_pkg::fslet_ops_t ops_i = '0;
    logic [3:0] cycle_i = 4'h0;
    logic [31:0] z_bus_i = 32'h0;
    logic [31:0] d_bus_i = 32'h0;
    logic [31:0] outr_i = 32'h0;
    fslet_pkg::fslet_indata_t indata_i = '0;
    fslet_pkg::fslet_proc_t proc_i = '0;
    logic [13:0] control_store_address = A;
    logic [7:0] resp_dly = 8'h03;
    logic [95:0] rom_word;
    logic xact_resp;
    logic [95:0] cs_word_o;
    logic cs_valid_o;
    logic ram_select_o;
    logic [7:0] syndrome_o;
    logic error_o;
    logic trap_o;
    logic [3:0] out_par_o;
    int num_errors = 0;
    int total_checks = 0;
    int n;
    fslet_row_t rows [5] = '{{1'b0, 1'b0, 32'h0, 4'hf}, {1'b0, 1'b0, 32'h0102_0304, 4'h2},
        {1'b1, 1'b0, 32'h0102_0304, 4'hd}, {1'b1, 1'b1, 32'hff00_ff01, 4'he},
        {1'b1, 1'b0, 32'h0, 4'h0}};

    fslet_top dut (.clk_i(clk_i), .srst_i(srst_i), .init_i(init_i), .step_i(step_i),
        .ops_i(ops_i), .cycle_i(cycle_i), .error_trap_inhibit_flag_i(inh), .z_bus_i(z_bus_i),
        .d_bus_i(d_bus_i), .indata_i(indata_i), .proc_i(proc_i), .xact_start_i(xact_start_i),
        .xact_resp_i(xact_resp), .fetch_i(fetch_i), .control_store_address_i(control_store_address),
        .rom_word_i(rom_word), .cs_word_o(cs_word_o), .cs_valid_o(cs_valid_o),
        .ram_select_o(ram_select_o), .syndrome_o(syndrome_o), .error_o(error_o),
        .trap_o(trap_o), .outr_i(outr_i), .test_mode_i(test_mode_i),
        .test_par_odd_i(test_par_odd_i), .out_par_o(out_par_o));
    fslet_far_model far (.clk_i(clk_i), .addr_i(control_store_address), .bad_par_i(bad_par),
        .rom_word_o(rom_word), .xact_start_i(xact_start_i), .resp_dly_i(resp_dly),
        .xact_resp_o(xact_resp));

    always #5 clk_i = ~clk_i;

    function automatic logic [95:0] rw(input logic [13:0] a, input logic bad);
        rw = {3{~^a, 17'h00000, a}} ^ {64'h0, bad, 31'h0};
    endfunction

    task automatic do_step(input fslet_pkg::fslet_ops_t o, input logic [3:0] c,
        input logic [31:0] z, input logic [31:0] d);
        @(posedge clk_i);
        step_i <= 1'b1;
        ops_i <= o;
        cycle_i <= c;
        z_bus_i <= z;
        d_bus_i <= d;
        @(posedge clk_i);
        step_i <= 1'b0;
        ops_i <= '0;
        #1;
    endtask

    task automatic fetch(input logic [13:0] a, input logic [95:0] w);
        int i;
        i = 0;
        @(posedge clk_i);
        fetch_i <= 1'b1;
        control_store_address <= a;
        @(posedge clk_i);
        fetch_i <= 1'b0;
        do begin
            @(posedge clk_i);
            #1;
            i++;
        end while (cs_valid_o !== 1'b1 && i < 4);
        `CHK(cs_valid_o, 1'b1)
        `CHK(cs_word_o, w)
    endtask

    task automatic err_case(input fslet_pkg::fslet_ops_t o, input logic ih, input logic [7:0] s);
        @(posedge clk_i);
        inh <= ih;
        do_step(o, 4'h0, 32'h0, 32'h0);
        `CHK(error_o, 1'b1)
        `CHK(syndrome_o, s)
        `CHK(trap_o, !ih)
    endtask

    task automatic init_pulse;
        @(posedge clk_i);
        init_i <= 1'b1;
        @(posedge clk_i);
        init_i <= 1'b0;
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        wrap_up;
    end

    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        `CHK(ram_select_o, 1'b0)
        `CHK(syndrome_o, 8'h00)
        foreach (rows[i]) begin
            @(posedge clk_i);
            test_mode_i <= rows[i].tm;
            test_par_odd_i <= rows[i].odd;
            outr_i <= rows[i].outr;
            @(posedge clk_i);
            #1;
            `CHK(out_par_o, rows[i].par)
        end
        // load sequence as a loader started by function 29 would issue it
        do_step(OP_WR, 4'h1, 32'h0, {18'h3ffff, A});
        for (int c = 2; c < 8; c++) begin
            do_step(OP_WR, {1'b1, 3'(c)}, {16'hffff, c[0] ? 16'h1100 : 16'h0007}, 32'h0);
        end
        do_step(OP_WR, 4'h8, 32'h0, 32'h0);
        do_step(OP_RAM, 4'h0, 32'h0, 32'h0);
        `CHK(ram_select_o, 1'b0)
        fetch(A, rw(A, 1'b0));
        do_step('0, 4'h0, 32'h0, 32'h0);
        `CHK(ram_select_o, 1'b1)
        fetch(A, LW);
        @(posedge clk_i);
        #1;
        `CHK(error_o, 1'b0)
        // writes while running from ram are dropped
        do_step(OP_WR, 4'h2, 32'h0000_ffff, 32'h0);
        do_step(OP_WR, 4'h0, 32'h0, 32'h0);
        fetch(A, LW);
        do_step(OP_RAM, 4'h0, 32'h0, 32'h0);
        do_step('0, 4'h0, 32'h0, 32'h0);
        `CHK(ram_select_o, 1'b1)
        do_step(OP_ROM, 4'h0, 32'h0, 32'h0);
        `CHK(ram_select_o, 1'b1)
        do_step('0, 4'h0, 32'h0, 32'h0);
        `CHK(ram_select_o, 1'b0)
        do_step(OP_RAM, 4'h0, 32'h0, 32'h0);
        do_step('0, 4'h0, 32'h0, 32'h0);
        init_pulse;
        `CHK(ram_select_o, 1'b0)
        do_step(OP_RAM, 4'h0, 32'h0, 32'h0);
        init_pulse;
        do_step('0, 4'h0, 32'h0, 32'h0);
        `CHK(ram_select_o, 1'b0)
        // errors: disabled byte ignored, then each source reason and store group 0 parity
        @(posedge clk_i);
        indata_i <= {32'h0, 4'h1, 4'h1, 1'b0};
        do_step(OP_INA, 4'h0, 32'h0, 32'h0);
        `CHK(error_o, 1'b0)
        @(posedge clk_i);
        indata_i <= {32'h0, 4'h0, 4'h1, 1'b0};
        err_case(OP_INA, 1'b0, 8'h01);
        @(posedge clk_i);
        proc_i <= {8'h00, 1'b0, 1'b0};
        err_case(OP_PT, 1'b1, 8'h02);
        @(posedge clk_i);
        proc_i <= {8'h00, 1'b1, 1'b1};
        indata_i <= {32'h0, 4'h1, 4'h1, 1'b1};
        err_case(OP_INB | OP_DP, 1'b0, 8'h0c);
        @(posedge clk_i);
        bad_par <= 1'b1;
        fetch(14'h0005, rw(14'h0005, 1'b1));
        @(posedge clk_i);
        bad_par <= 1'b0;
        #1;
        `CHK(syndrome_o, 8'h20)
        `CHK(trap_o, 1'b1)
        // system bus answers promptly, slowly, then never
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            resp_dly <= (k == 0) ? 8'h03 : ((k == 1) ? 8'h96 : 8'h00);
            xact_start_i <= 1'b1;
            @(posedge clk_i);
            xact_start_i <= 1'b0;
            n = 0;
            do begin
                @(posedge clk_i);
                #1;
                n++;
            end while (error_o !== 1'b1 && n < 230);
            `CHK(n == 230, k < 2)
        end
        `CHK(syndrome_o, 8'h10)
        `CHK(n, fslet_pkg::NORESP_CYC)
        // reset in mid-run drops the ram select and the syndrome
        do_step(OP_RAM, 4'h0, 32'h0, 32'h0);
        do_step('0, 4'h0, 32'h0, 32'h0);
        `CHK(ram_select_o, 1'b1)
        @(posedge clk_i);
        srst_i <= 1'b1;
        @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        `CHK(ram_select_o, 1'b0)
        `CHK(syndrome_o, 8'h00)
        `CHK(error_o, 1'b0)
        err_case(OP_INB, 1'b0, 8'h04);
        wrap_up;
    end
endmodule
`default_nettype wire
